// ==== src/rtc_cfg_pkg.sv ====
/*
 Shared constants for the clock configuration and value window block:
 register offsets, field positions, reset values, value limits and timing.
 Assumes a 100 MHz system clock and a 16-bit register port.
*/
package rtc_cfg_pkg;
    // ==========================================================
    // Timing
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned HALF_SEC_NS     = 500_000_000;
    localparam int unsigned HALF_SEC_CYCLES = HALF_SEC_NS / CLK_PERIOD_NS;
    // Read-sync guard ahead of each rollover, least time, rounded up
    localparam int unsigned SYNC_WINDOW_NS  = 1_000;
    localparam int unsigned SYNC_CYCLES     =
        (SYNC_WINDOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SYNC_AFTER      = 2;  // Guard cycles after the tick

    // ==========================================================
    // Register offsets (word index on the register port)
    localparam logic [1:0] OFS_CONFIG     = 2'h0;
    localparam logic [1:0] OFS_VALUE_HIGH = 2'h1;
    localparam logic [1:0] OFS_VALUE_LOW  = 2'h2;

    // ==========================================================
    // Field positions of clock_config_and_trim
    localparam int unsigned ENABLE_BIT = 15;
    localparam int unsigned UNLOCK_BIT = 13;
    localparam int unsigned SYNC_BIT   = 12;
    localparam int unsigned HALF_BIT   = 11;
    localparam int unsigned OE_BIT     = 10;
    localparam int unsigned PTR_LSB    = 8;
    localparam int unsigned TRIM_LSB   = 0;
    localparam logic [15:0] CONFIG_RESET = 16'h0000;

    // ==========================================================
    // Window pointer codes
    localparam logic [1:0] PTR_MIN_SEC    = 2'h0;
    localparam logic [1:0] PTR_WDAY_HOUR  = 2'h1;
    localparam logic [1:0] PTR_MONTH_DAY  = 2'h2;
    localparam logic [1:0] PTR_RSVD_YEAR  = 2'h3;

    // ==========================================================
    // Field limits and reset values of the time fields
    localparam logic [7:0] ZERO_BYTE  = 8'h00;
    localparam logic [7:0] SEC_MAX    = 8'h3B;
    localparam logic [7:0] MIN_MAX    = 8'h3B;
    localparam logic [7:0] HOUR_MAX   = 8'h17;
    localparam logic [7:0] WDAY_MAX   = 8'h06;
    localparam logic [7:0] DAY_FIRST  = 8'h01;
    localparam logic [7:0] DAY_MAX    = 8'h1F;
    localparam logic [7:0] MONTH_MAX  = 8'h0C;
    localparam logic [7:0] YEAR_MAX   = 8'h63;
endpackage

// ==== src/half_sec_divider.sv ====
/*
 Half-second divider: counts system clocks, holds the half-second phase,
 pulses once per full second and raises the read-sync guard around it.
 Assumes one clock and a synchronous active-high power-on reset.
*/
`timescale 1ns/100ps
module half_sec_divider #(
    parameter int unsigned HALF_CYCLES = rtc_cfg_pkg::HALF_SEC_CYCLES,
    parameter int unsigned SYNC_CYCLES = rtc_cfg_pkg::SYNC_CYCLES
) (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic run,
    input  wire logic restart,
    output logic      half_flag,
    output logic      sec_tick,
    output logic      sync_flag
);
    generate
        if (HALF_CYCLES <= SYNC_CYCLES + rtc_cfg_pkg::SYNC_AFTER) begin : g_bad
            $error("half_sec_divider: HALF_CYCLES too small for sync window");
        end
    endgenerate

    localparam logic [31:0] LAST   = 32'(HALF_CYCLES - 1);
    localparam logic [31:0] GUARD  = 32'(HALF_CYCLES - SYNC_CYCLES);
    localparam logic [31:0] AFTER  = 32'(rtc_cfg_pkg::SYNC_AFTER);

    typedef struct packed {
        logic [31:0] cnt;
        logic        phase;
        logic        tick;
        logic        sync;
    } div_state_t;

    div_state_t state_r;
    div_state_t state_nxt;

    // ==========================================================
    // Next state: restart beats counting, a stopped unit holds its phase
    always_comb begin
        state_nxt      = state_r;
        state_nxt.tick = 1'b0;
        if (restart) begin
            state_nxt.cnt   = 32'h0000_0000;
            state_nxt.phase = 1'b0;
        end else if (run) begin
            if (state_r.cnt == LAST) begin
                state_nxt.cnt   = 32'h0000_0000;
                state_nxt.phase = ~state_r.phase;
                state_nxt.tick  = state_r.phase;
            end else begin
                state_nxt.cnt = state_r.cnt + 32'h0000_0001;
            end
        end
        // Guard covers the end of the second and the update just after it
        state_nxt.sync = run && !restart &&
            ((state_nxt.phase && state_nxt.cnt >= GUARD) ||
             (!state_nxt.phase && state_nxt.cnt < AFTER));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign half_flag = state_r.phase;
    assign sec_tick  = state_r.tick;
    assign sync_flag = state_r.sync;
endmodule

// ==== src/value_window_mux.sv ====
/*
 Value window selector: presents the high and low time bytes chosen by
 the two-bit window pointer. Purely combinational.
*/
`timescale 1ns/100ps
module value_window_mux (
    input  wire logic [1:0] ptr,
    input  wire logic [7:0] sec,
    input  wire logic [7:0] min,
    input  wire logic [7:0] hour,
    input  wire logic [7:0] wday,
    input  wire logic [7:0] day,
    input  wire logic [7:0] month,
    input  wire logic [7:0] year,
    output logic [7:0]      hi_byte,
    output logic [7:0]      lo_byte
);
    // ==========================================================
    // One decode shared by both byte lanes
    function automatic logic [7:0] pick(input logic [1:0] p, input logic [7:0] b0,
                                        input logic [7:0] b1, input logic [7:0] b2,
                                        input logic [7:0] b3);
        case (p)
            rtc_cfg_pkg::PTR_MIN_SEC:   pick = b0;
            rtc_cfg_pkg::PTR_WDAY_HOUR: pick = b1;
            rtc_cfg_pkg::PTR_MONTH_DAY: pick = b2;
            default:                    pick = b3;
        endcase
    endfunction

    assign hi_byte = pick(ptr, min, wday, month, rtc_cfg_pkg::ZERO_BYTE);
    assign lo_byte = pick(ptr, sec, hour, day, year);
endmodule

// ==== src/rtc_config_and_value_pointer.sv ====
/*
 Clock and calendar configuration block: the clock_config_and_trim word,
 the value window pointer, the time value register pair and a small
 seconds-to-years counter driven by the half-second divider.
 Assumes one 100 MHz clock, rst as the power-on reset, and software on a
 plain register port with read data one cycle after the read strobe.
*/
`timescale 1ns/100ps
module rtc_config_and_value_pointer #(
    parameter int unsigned HALF_CYCLES = rtc_cfg_pkg::HALF_SEC_CYCLES,
    parameter int unsigned SYNC_CYCLES = rtc_cfg_pkg::SYNC_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        sys_rst,
    input  wire logic [1:0]  addr,
    input  wire logic [15:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [15:0]      rdata,
    output logic             clock_out,
    output logic             unit_running,
    output logic [7:0]       drift_trim
);
    generate
        if (SYNC_CYCLES < 1) begin : g_bad_sync
            $error("rtc_config_and_value_pointer: SYNC_CYCLES must be at least 1");
        end
    endgenerate

    // ==========================================================
    // State
    typedef struct packed {
        logic        enable;
        logic        unlock;
        logic        oe;
        logic [1:0]  ptr;
        logic [7:0]  trim;
        logic [7:0]  sec;
        logic [7:0]  min;
        logic [7:0]  hour;
        logic [7:0]  wday;
        logic [7:0]  day;
        logic [7:0]  month;
        logic [7:0]  year;
        logic [15:0] rdata;
        logic        clk_out;
    } top_state_t;

    top_state_t state_r;
    top_state_t state_nxt;

    logic       half_flag;
    logic       sec_tick;
    logic       sync_flag;
    logic [7:0] win_hi;
    logic [7:0] win_lo;
    logic       wr_cfg;
    logic       wr_hi;
    logic       wr_lo;
    logic       acc_hi;
    logic       sec_write;

    // ==========================================================
    // Helpers
    // One step of a wrapping field; returns carry out above the value
    function automatic logic [8:0] step(input logic [7:0] v, input logic [7:0] lo,
                                        input logic [7:0] hi, input logic cin);
        if (!cin) begin
            step = {1'b0, v};
        end else if (v >= hi) begin
            step = {1'b1, lo};
        end else begin
            step = {1'b0, v + 8'h01};
        end
    endfunction

    // Assemble the configuration word as software sees it
    function automatic logic [15:0] cfg_word(input top_state_t s, input logic sync,
                                             input logic half);
        logic [15:0] w;
        w = rtc_cfg_pkg::CONFIG_RESET;                   // Bit 14 stays zero
        w[rtc_cfg_pkg::ENABLE_BIT] = s.enable;
        w[rtc_cfg_pkg::UNLOCK_BIT] = s.unlock;
        w[rtc_cfg_pkg::SYNC_BIT]   = sync;
        w[rtc_cfg_pkg::HALF_BIT]   = half;
        w[rtc_cfg_pkg::OE_BIT]     = s.oe;
        w[rtc_cfg_pkg::PTR_LSB +: 2]  = s.ptr;
        w[rtc_cfg_pkg::TRIM_LSB +: 8] = s.trim;
        cfg_word = w;
    endfunction

    // ==========================================================
    // Access decode
    assign wr_cfg = wr && (addr == rtc_cfg_pkg::OFS_CONFIG);
    assign wr_hi  = wr && (addr == rtc_cfg_pkg::OFS_VALUE_HIGH) && state_r.unlock;
    assign wr_lo  = wr && (addr == rtc_cfg_pkg::OFS_VALUE_LOW) && state_r.unlock;
    // Any strobe on the high register moves the window, locked or not
    assign acc_hi = (wr || rd) && (addr == rtc_cfg_pkg::OFS_VALUE_HIGH);
    // Writing the seconds byte restarts the half-second phase
    // A high write carries the seconds byte too, so it restarts as well
    assign sec_write = (wr_lo || wr_hi) && (state_r.ptr == rtc_cfg_pkg::PTR_MIN_SEC);

    // ==========================================================
    // Divider and window selector
    half_sec_divider #(
        .HALF_CYCLES (HALF_CYCLES),
        .SYNC_CYCLES (SYNC_CYCLES)
    ) u_div (
        .clk       (clk),
        .rst       (rst),
        .run       (state_r.enable),
        .restart   (sec_write),
        .half_flag (half_flag),
        .sec_tick  (sec_tick),
        .sync_flag (sync_flag)
    );

    value_window_mux u_mux (
        .ptr     (state_r.ptr),
        .sec     (state_r.sec),
        .min     (state_r.min),
        .hour    (state_r.hour),
        .wday    (state_r.wday),
        .day     (state_r.day),
        .month   (state_r.month),
        .year    (state_r.year),
        .hi_byte (win_hi),
        .lo_byte (win_lo)
    );

    // ==========================================================
    // Next state
    always_comb begin
        logic [8:0] s_sec;
        logic [8:0] s_min;
        logic [8:0] s_hour;
        logic [8:0] s_wday;
        logic [8:0] s_day;
        logic [8:0] s_month;
        logic [8:0] s_year;
        state_nxt = state_r;

        // Counting cascade, one step per second while running
        s_sec   = step(state_r.sec, rtc_cfg_pkg::ZERO_BYTE, rtc_cfg_pkg::SEC_MAX,
                       sec_tick && state_r.enable);
        s_min   = step(state_r.min, rtc_cfg_pkg::ZERO_BYTE, rtc_cfg_pkg::MIN_MAX,
                       s_sec[8]);
        s_hour  = step(state_r.hour, rtc_cfg_pkg::ZERO_BYTE, rtc_cfg_pkg::HOUR_MAX,
                       s_min[8]);
        s_wday  = step(state_r.wday, rtc_cfg_pkg::ZERO_BYTE, rtc_cfg_pkg::WDAY_MAX,
                       s_hour[8]);
        // Month length is not modelled; every month runs to day 31
        s_day   = step(state_r.day, rtc_cfg_pkg::DAY_FIRST, rtc_cfg_pkg::DAY_MAX,
                       s_hour[8]);
        s_month = step(state_r.month, rtc_cfg_pkg::DAY_FIRST, rtc_cfg_pkg::MONTH_MAX,
                       s_day[8]);
        s_year  = step(state_r.year, rtc_cfg_pkg::ZERO_BYTE, rtc_cfg_pkg::YEAR_MAX,
                       s_month[8]);
        state_nxt.sec   = s_sec[7:0];
        state_nxt.min   = s_min[7:0];
        state_nxt.hour  = s_hour[7:0];
        state_nxt.wday  = s_wday[7:0];
        state_nxt.day   = s_day[7:0];
        state_nxt.month = s_month[7:0];
        state_nxt.year  = s_year[7:0];

        // Configuration write; flags 12 and 11 are not stored here
        if (wr_cfg) begin
            state_nxt.unlock = wdata[rtc_cfg_pkg::UNLOCK_BIT];
            state_nxt.oe     = wdata[rtc_cfg_pkg::OE_BIT];
            state_nxt.ptr    = wdata[rtc_cfg_pkg::PTR_LSB +: 2];
            state_nxt.trim   = wdata[rtc_cfg_pkg::TRIM_LSB +: 8];
            if (state_r.unlock) begin
                state_nxt.enable = wdata[rtc_cfg_pkg::ENABLE_BIT];
            end
        end

        // High value write: software data beats a same-cycle rollover
        if (wr_hi) begin
            case (state_r.ptr)
                rtc_cfg_pkg::PTR_MIN_SEC:   state_nxt.min   = wdata[15:8];
                rtc_cfg_pkg::PTR_WDAY_HOUR: state_nxt.wday  = wdata[15:8];
                rtc_cfg_pkg::PTR_MONTH_DAY: state_nxt.month = wdata[15:8];
                default:                    state_nxt.min   = state_nxt.min;
            endcase
            case (state_r.ptr)
                rtc_cfg_pkg::PTR_MIN_SEC:   state_nxt.sec   = wdata[7:0];
                rtc_cfg_pkg::PTR_WDAY_HOUR: state_nxt.hour  = wdata[7:0];
                rtc_cfg_pkg::PTR_MONTH_DAY: state_nxt.day   = wdata[7:0];
                default:                    state_nxt.year  = wdata[7:0];
            endcase
        end

        // Low value write fills the low byte only
        if (wr_lo) begin
            case (state_r.ptr)
                rtc_cfg_pkg::PTR_MIN_SEC:   state_nxt.sec   = wdata[7:0];
                rtc_cfg_pkg::PTR_WDAY_HOUR: state_nxt.hour  = wdata[7:0];
                rtc_cfg_pkg::PTR_MONTH_DAY: state_nxt.day   = wdata[7:0];
                default:                    state_nxt.year  = wdata[7:0];
            endcase
        end

        // Window pointer walks down after each high access, stuck at 00
        if (acc_hi && state_r.ptr != rtc_cfg_pkg::PTR_MIN_SEC) begin
            state_nxt.ptr = state_r.ptr - 2'h1;
        end

        // Read data for the cycle after the strobe
        if (rd) begin
            case (addr)
                rtc_cfg_pkg::OFS_CONFIG:
                    state_nxt.rdata = cfg_word(state_r, sync_flag, half_flag);
                rtc_cfg_pkg::OFS_VALUE_HIGH,
                rtc_cfg_pkg::OFS_VALUE_LOW:
                    state_nxt.rdata = {win_hi, win_lo};
                default:
                    state_nxt.rdata = 16'h0000;
            endcase
        end else begin
            state_nxt.rdata = 16'h0000;
        end

        // Output pin follows the half-second phase only when enabled
        state_nxt.clk_out = state_r.oe && state_r.enable && half_flag;
    end

    // ==========================================================
    // State register
    // Only power-on reset touches configuration; a system reset merely
    // clears pending read data so that a reset bus sees a quiet port.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_r       <= '0;
            state_r.day   <= rtc_cfg_pkg::DAY_FIRST;
            state_r.month <= rtc_cfg_pkg::DAY_FIRST;
        end else if (sys_rst) begin
            state_r       <= state_nxt;
            state_r.rdata <= 16'h0000;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Outputs, all straight from the state register
    assign rdata        = state_r.rdata;
    assign clock_out    = state_r.clk_out;
    assign unit_running = state_r.enable;
    assign drift_trim   = state_r.trim;
endmodule

// ==== dv/rtc_cfg_sva.sv ====
/*
 Port-level checker for the clock configuration and value window block.
 Assumes it is bound to the top module and sees only that module's ports.
*/
`timescale 1ns/100ps
module rtc_cfg_sva #(
    parameter int unsigned HALF_CYCLES = 20,
    parameter int unsigned SYNC_CYCLES = 3
) (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic        sys_rst,
    input wire logic [1:0]  addr,
    input wire logic [15:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [15:0] rdata,
    input wire logic        clock_out,
    input wire logic        unit_running,
    input wire logic [7:0]  drift_trim
);
    // ==========================================================
    // Shadow of the software fields
    logic        en_r;
    logic        unlock_r;
    logic        oe_r;
    logic        co_r;
    logic [1:0]  ptr_r;
    logic [7:0]  trim_r;
    int unsigned run_r;
    logic [15:0] cfg_exp;

    // Flags at 12 and 11 move on their own, so they are left out here
    assign cfg_exp = {en_r, 1'b0, unlock_r, 2'h0, oe_r, ptr_r, trim_r};

    // Shadow registers follow writes; enable needs the old unlock value
    always_ff @(posedge clk) begin
        if (rst) begin
            en_r     <= 1'b0;
            unlock_r <= 1'b0;
            oe_r     <= 1'b0;
            ptr_r    <= 2'h0;
            trim_r   <= 8'h00;
        end else if (wr && addr == 2'h0) begin
            en_r     <= unlock_r ? wdata[15] : en_r;
            unlock_r <= wdata[13];
            oe_r     <= wdata[10];
            ptr_r    <= wdata[9:8];
            trim_r   <= wdata[7:0];
        end else if ((wr || rd) && addr == 2'h1 && ptr_r != 2'h0) begin
            ptr_r <= ptr_r - 2'h1;
        end
    end

    // Length of each steady stretch of the output pin
    always_ff @(posedge clk) begin
        co_r <= clock_out;
        if (rst || clock_out != co_r || (wr && addr != 2'h0) || !(unit_running && oe_r)) begin
            run_r <= 0;
        end else begin
            run_r <= run_r + 1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ==========================================================
    // Properties
    a_cfg_readback: assert property (
        rd && addr == 2'h0 && !sys_rst |=> (rdata & 16'hE7FF) == $past(cfg_exp))
        else $error("config readback differs from written fields");
    a_hi_reserved: assert property (
        rd && addr == 2'h1 && ptr_r == 2'h3 && !sys_rst |=> rdata[15:8] == 8'h00)
        else $error("reserved high byte not zero");
    a_rdata_idle: assert property (!rd |=> rdata == 16'h0000)
        else $error("read data outside read slot");
    a_enable_follow: assert property (
        $stable(en_r) [*2] |-> unit_running == en_r)
        else $error("running output differs from enable");
    a_trim_follow: assert property (
        $stable(trim_r) [*2] |-> drift_trim == trim_r)
        else $error("trim output differs from trim field");
    a_out_gated: assert property (
        (!unit_running || !oe_r) [*3] |-> !clock_out)
        else $error("clock output active while gated");
    a_half_length: assert property (
        run_r <= HALF_CYCLES + 3)
        else $error("output pin steady longer than half a second");
    a_sync_idle: assert property (
        !unit_running [*3] ##0 (rd && addr == 2'h0 && !sys_rst) |=> !rdata[12])
        else $error("read sync set while stopped");

    c_value_write: cover property (wr && addr == 2'h1);
    c_sync_seen: cover property (rd && addr == 2'h0 ##1 rdata[12]);
    c_out_rose: cover property ($rose(clock_out));
endmodule

bind rtc_config_and_value_pointer rtc_cfg_sva #(
    .HALF_CYCLES(HALF_CYCLES),
    .SYNC_CYCLES(SYNC_CYCLES)
) u_sva (
    .clk          (clk),
    .rst          (rst),
    .sys_rst      (sys_rst),
    .addr         (addr),
    .wdata        (wdata),
    .wr           (wr),
    .rd           (rd),
    .rdata        (rdata),
    .clock_out    (clock_out),
    .unit_running (unit_running),
    .drift_trim   (drift_trim)
);

// ==== dv/rtc_config_and_value_pointer_tb.sv ====
/*
 Self-checking testbench for the clock configuration block.
 Assumes the checker is bound in; short divider counts keep the run brief.
*/
`timescale 1ns/100ps
module rtc_config_and_value_pointer_tb;
    localparam int unsigned HALF = 20;
    localparam int unsigned SYNC = 3;
    logic        clk;
    logic        rst;
    logic        sys_rst;
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
    logic [15:0] rdata;
    logic        clock_out;
    logic        unit_running;
    logic [7:0]  drift_trim;
    logic [15:0] d;
    int          n_errors;
    int          cmp_count;

    rtc_config_and_value_pointer #(.HALF_CYCLES(HALF), .SYNC_CYCLES(SYNC)) DUT (
        .clk          (clk),
        .rst          (rst),
        .sys_rst      (sys_rst),
        .addr         (addr),
        .wdata        (wdata),
        .wr           (wr),
        .rd           (rd),
        .rdata        (rdata),
        .clock_out    (clock_out),
        .unit_running (unit_running),
        .drift_trim   (drift_trim)
    );

    // ==========================================================
    // Clock and shared tasks
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s: expected %h seen %h", what, exp, got);
        end
    endtask

    // Strobe drops one cycle before the next access, so no double drive
    task automatic wr_reg(input logic [1:0] a, input logic [15:0] v);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask

    // Read data stands only in the cycle after the strobe
    task automatic rd_reg(input logic [1:0] a, output logic [15:0] v);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_lock();
        rd_reg(2'h3, d);
        chk("unmapped", 16'h0000, d);
        wr_reg(2'h2, 16'h0005);
        rd_reg(2'h2, d);
        chk("locked value", 16'h0000, d);
        wr_reg(2'h0, 16'hFFFF);
        rd_reg(2'h0, d);
        chk("config", 16'h27FF, d);
        chk("trim", 16'h00FF, {8'h00, drift_trim});
        chk("running", 16'h0000, {15'h0000, unit_running});
        $display("lock test done");
    endtask

    task automatic t_window();
        logic [15:0] exp [5] = '{16'h0063, 16'h0C1F, 16'h0617, 16'h3B3A, 16'h3B3A};
        wr_reg(2'h0, 16'h2300);
        wr_reg(2'h1, 16'h5563);
        wr_reg(2'h1, 16'h0C1F);
        wr_reg(2'h1, 16'h0617);
        wr_reg(2'h1, 16'h3B3A);
        wr_reg(2'h0, 16'h2300);
        for (int i = 0; i < 5; i++) begin
            rd_reg(2'h1, d);
            chk("window", exp[i], d);
        end
        wr_reg(2'h0, 16'h2100);
        wr_reg(2'h2, 16'hFF05);
        repeat (2) begin
            rd_reg(2'h2, d);
            chk("low write", 16'h0605, d);
        end
        wr_reg(2'h0, 16'h0000);
        wr_reg(2'h1, 16'h1111);
        rd_reg(2'h2, d);
        chk("locked pair", 16'h3B3A, d);
        $display("window test done");
    endtask

    task automatic t_enable();
        wr_reg(2'h0, 16'h8000);
        chk("enable locked", 16'h0000, {15'h0000, unit_running});
        wr_reg(2'h0, 16'h2000);
        wr_reg(2'h0, 16'hA400);
        @(posedge clk);
        chk("enable", 16'h0001, {15'h0000, unit_running});
        $display("enable test done");
    endtask

    // Back-to-back reads over one full second count the flags
    task automatic t_sync_half();
        int ns;
        int nh;
        int nc;
        logic [15:0] d1;
        ns = 0;
        nh = 0;
        nc = 0;
        rd   <= 1'b1;
        addr <= 2'h0;
        @(posedge clk);
        for (int i = 0; i < 2 * HALF; i++) begin
            @(posedge clk);
            ns += rdata[12];
            nh += rdata[11];
            nc += clock_out;
        end
        rd <= 1'b0;
        @(posedge clk);
        chk("sync count", 16'(SYNC + 2), 16'(ns));
        chk("half count", 16'(HALF), 16'(nh));
        chk("output count", 16'(HALF), 16'(nc));
        // Wait for a read-sync window, then trust a value only if two reads agree
        d = 16'h0000;
        for (int k = 0; k < 2 * HALF && !d[12]; k++) begin
            rd_reg(2'h0, d);
        end
        chk("sync seen", 16'h0001, {15'h0000, d[12]});
        for (int k = 0; k < 4; k++) begin
            rd_reg(2'h2, d1);
            rd_reg(2'h2, d);
            if (d1 === d) begin
                break;
            end
        end
        chk("double read", d1, d);
        $display("sync test done");
    endtask

    task automatic t_half_clear();
        int n;
        n = 0;
        while (clock_out !== 1'b1) begin
            n++;
            if (n > 4 * HALF) begin
                n_errors++;
                final_report();
            end
            @(posedge clk);
        end
        wr_reg(2'h2, 16'h0000);
        rd_reg(2'h0, d);
        chk("half cleared", 16'h0000, {15'h0000, d[11]});
        chk("output low", 16'h0000, {15'h0000, clock_out});
        $display("half clear test done");
    endtask

    task automatic t_sys_rst();
        sys_rst <= 1'b1;
        rd_reg(2'h0, d);
        chk("read under reset", 16'h0000, d);
        sys_rst <= 1'b0;
        rd_reg(2'h0, d);
        chk("config kept", 16'hA400, d & 16'hE7FF);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd_reg(2'h0, d);
        chk("config cleared", 16'h0000, d);
        chk("stopped", 16'h0000, {15'h0000, unit_running});
        $display("reset test done");
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst       = 1'b1;
        sys_rst   = 1'b0;
        addr      = 2'h0;
        wdata     = 16'h0000;
        wr        = 1'b0;
        rd        = 1'b0;
        n_errors  = 0;
        cmp_count = 0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_lock();
        t_window();
        t_enable();
        t_sync_half();
        t_half_clear();
        t_sys_rst();
        final_report();
    end
endmodule
